//--- cfo_pkg.sv
// Constants and carrier types for the concatenating output framer.
// Assumes one core clock; all users refer to names as cfo_pkg::name.
package cfo_pkg;

   // Register offsets on the byte-wide register port
   localparam logic [7:0] REG_GEN_CFG  = 8'h02;
   localparam logic [7:0] REG_FWD_ONE  = 8'h20;
   localparam logic [7:0] REG_FWD_TWO  = 8'h21;
   localparam logic [7:0] REG_TX_CTL   = 8'h33;
   localparam logic [7:0] REG_STATUS   = 8'h34;

   // Field positions and reset values
   localparam int         GEN_SLEEP_BIT = 0;
   localparam int         GEN_OEN_BIT   = 1;
   localparam logic [7:0] GEN_RESET     = 8'h03;
   localparam logic [7:0] FWD_ONE_RESET = 8'hF0;   // All forwarding disabled
   localparam logic [7:0] FWD_TWO_RESET = 8'h00;
   localparam logic [7:0] TX_CTL_RESET  = 8'h00;
   localparam int         FWD_TWO_REPL  = 7;
   localparam int         TX_EN_BIT     = 0;

   // Geometry
   localparam int          NUM_RX     = 4;
   localparam int          BUF_AW     = 10;
   localparam int          BUF_BYTES  = 1024;
   localparam logic [10:0] BUF_FULL   = 11'h400;
   localparam int          FIFO_DEPTH = 16;
   localparam int          FIFO_W     = 9;

   // Packet layout
   localparam logic [10:0] HDR_LEN  = 11'h004;
   localparam logic [10:0] FTR_LAST = 11'h005;
   localparam logic [5:0]  DT_FS    = 6'h00;
   localparam logic [5:0]  DT_FE    = 6'h01;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h8408;

   typedef enum logic [1:0] {K_DATA, K_LAST, K_FS, K_FE} cfo_kind_e;
   typedef enum logic [1:0] {E_FS, E_FE, E_LINE} cfo_emit_e;

   // One beat from a receive port
   typedef struct packed {
      cfo_kind_e  kind;
      logic [1:0] vc;
      logic [5:0] dt;
      logic [7:0] data;
   } cfo_rx_beat_s;

   // State of one transmit port's pins
   typedef struct packed {
      logic       drive;
      logic       hs_zero;
      logic       valid;
      logic       last;
      logic [7:0] data;
   } cfo_tx_pin_s;

endpackage

//--- cfo_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cfo_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   // Full and empty come straight from the occupancy count
   assign o_ready = (cnt_q != (AW+1)'(DEPTH));
   assign o_valid = (cnt_q != '0);
   assign o_data  = mem[rd_q];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   // Storage write
   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[wr_q] <= i_data;
   end

   // Pointers and count
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

//--- cfo_top.sv
// Line-concatenating forwarder and two-port output control.
// Assumes receive beats and lock come from core-clock logic; the power-down
// pin and the transmit byte clock arrive from outside and are synchronised.
`timescale 1ns/1ps
`default_nettype none
module cfo_top (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_power_down_bar_pin,
   input  wire logic                        i_tx_byte_clk,
   input  wire logic [3:0]                  i_rx_lock,
   input  wire logic [3:0]                  i_rx_valid,
   input  wire cfo_pkg::cfo_rx_beat_s [3:0] i_rx_beat,
   output logic [3:0]                       o_rx_ready,
   input  wire logic                        i_reg_wr,
   input  wire logic [7:0]                  i_reg_addr,
   input  wire logic [7:0]                  i_reg_wdata,
   output logic [7:0]                       o_reg_rdata,
   output cfo_pkg::cfo_tx_pin_s             o_tx_zero,
   output cfo_pkg::cfo_tx_pin_s             o_tx_one
);
   typedef enum {S_TAKE, S_EMIT} cfo_state_e;

   cfo_state_e            state_q, state_d;
   logic [7:0]            gen_q, fwd_one_q, fwd_two_q, tx_ctl_q;
   logic [1:0]            pdb_sync_q, bclk_sync_q;
   logic                  bclk_prev_q;
   logic [1:0]            port_q, port_d;
   logic                  fs_phase_q, fe_seen_q, port_done;
   cfo_pkg::cfo_emit_e    ek_q;
   logic [1:0]            vc_q;
   logic [5:0]            dt_q;
   logic [7:0]            buf_mem [0:cfo_pkg::BUF_BYTES-1];
   logic [10:0]           wr_ptr_q, ecnt_q;
   logic [15:0]           crc_q;
   logic [3:0]            en, map1, rdy_d;
   logic [2:0]            nxt, first;
   logic                  acc, is_data, emit_end, push_go;
   cfo_pkg::cfo_rx_beat_s beat;
   logic [8:0]            push_data, pop_data;
   logic                  push_rdy, pop_valid, pop, link_edge, repl;
   logic [1:0]            active, pins_ok;
   cfo_pkg::cfo_tx_pin_s  tx_q [0:1];

   // Disable bits in the upper nibble, map-to-port-one bits in the lower
   assign en        = ~fwd_one_q[7:4];
   assign map1      = fwd_one_q[3:0];
   assign repl      = fwd_two_q[cfo_pkg::FWD_TWO_REPL];
   assign beat      = i_rx_beat[port_q];
   assign acc       = |(i_rx_valid & o_rx_ready);
   assign is_data   = (beat.kind == cfo_pkg::K_DATA) || (beat.kind == cfo_pkg::K_LAST);
   assign link_edge = bclk_sync_q[1] && !bclk_prev_q;
   assign nxt       = next_en(port_q, en);
   assign first     = next_en(2'b00, {en[3:1], 1'b0}) | {1'b0, {2{1'b0}}};
   assign o_tx_zero = tx_q[0];
   assign o_tx_one  = tx_q[1];

   // CRC over payload bytes, least significant bit first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ cfo_pkg::CRC_POLY) : (r >> 1);
      return r;
   endfunction

   // Next enabled port above p, as {found, port}
   function automatic logic [2:0] next_en(input logic [1:0] p, input logic [3:0] e);
      logic [2:0] r;
      r = 3'b000;
      for (int i = cfo_pkg::NUM_RX - 1; i >= 0; i--)
         if (i > int'(p) && e[i])
            r = {1'b1, 2'(i)};
      return r;
   endfunction

   // Register writes from the register port
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         gen_q     <= cfo_pkg::GEN_RESET;
         fwd_one_q <= cfo_pkg::FWD_ONE_RESET;
         fwd_two_q <= cfo_pkg::FWD_TWO_RESET;
         tx_ctl_q  <= cfo_pkg::TX_CTL_RESET;
      end
      else if (i_reg_wr)
      begin
         case (i_reg_addr)
            cfo_pkg::REG_GEN_CFG: gen_q     <= i_reg_wdata;
            cfo_pkg::REG_FWD_ONE: fwd_one_q <= i_reg_wdata;
            cfo_pkg::REG_FWD_TWO: fwd_two_q <= i_reg_wdata;
            cfo_pkg::REG_TX_CTL:  tx_ctl_q  <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data; unmapped offsets read as zero, status shows live state
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
         o_reg_rdata <= 8'h00;
      else
      begin
         case (i_reg_addr)
            cfo_pkg::REG_GEN_CFG: o_reg_rdata <= gen_q;
            cfo_pkg::REG_FWD_ONE: o_reg_rdata <= fwd_one_q;
            cfo_pkg::REG_FWD_TWO: o_reg_rdata <= fwd_two_q;
            cfo_pkg::REG_TX_CTL:  o_reg_rdata <= tx_ctl_q;
            cfo_pkg::REG_STATUS:  o_reg_rdata <= {4'h0, (state_q == S_EMIT), fs_phase_q, active};
            default:              o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // Pin and byte clock synchronisers; only stage two is ever read
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         pdb_sync_q  <= 2'b00;
         bclk_sync_q <= 2'b00;
         bclk_prev_q <= 1'b0;
      end
      else
      begin
         pdb_sync_q  <= {pdb_sync_q[0], i_power_down_bar_pin};
         bclk_sync_q <= {bclk_sync_q[0], i_tx_byte_clk};
         bclk_prev_q <= bclk_sync_q[1];
      end
   end

   // Port walk: ports are visited in ascending order, one whole line or one frame marker each
   always_comb
   begin
      state_d   = state_q;
      port_d    = port_q;
      port_done = 1'b0;
      rdy_d     = 4'h0;
      if (state_q == S_TAKE && en != 4'h0)
      begin
         if (!en[port_q])
            port_done = 1'b1;
         else if (acc)
         begin
            case (beat.kind)
               cfo_pkg::K_FS:   port_done = fs_phase_q;
               cfo_pkg::K_FE:   port_done = !fs_phase_q;
               cfo_pkg::K_LAST: port_done = !fs_phase_q;
               default:         port_done = 1'b0;
            endcase
         end
         if (port_done && !nxt[2])
         begin
            state_d = S_EMIT;
            port_d  = en[0] ? 2'b00 : first[1:0];
         end
         else if (port_done)
            port_d = nxt[1:0];
      end
      else if (state_q == S_EMIT && emit_end)
         state_d = S_TAKE;
      if (state_d == S_TAKE && en[port_d])
         rdy_d[port_d] = 1'b1;
   end

   // Sequencer state and ready towards the receive ports
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         state_q    <= S_TAKE;
         port_q     <= 2'b00;
         o_rx_ready <= 4'h0;
      end
      else
      begin
         state_q    <= state_d;
         port_q     <= port_d;
         o_rx_ready <= rdy_d;
      end
   end

   // Frame phase, packet kind and header fields
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         fs_phase_q <= 1'b1;
         fe_seen_q  <= 1'b0;
         ek_q       <= cfo_pkg::E_FS;
         vc_q       <= 2'b00;
         dt_q       <= 6'h00;
      end
      else
      begin
         if (acc && port_q == (en[0] ? 2'b00 : first[1:0]))
            vc_q <= beat.vc;
         if (acc && is_data && !fs_phase_q && wr_ptr_q == 11'h000)
            dt_q <= beat.dt;
         if (acc && beat.kind == cfo_pkg::K_FE && !fs_phase_q)
            fe_seen_q <= 1'b1;
         if (state_q == S_TAKE && state_d == S_EMIT)
         begin
            if (fs_phase_q)
               ek_q <= cfo_pkg::E_FS;
            else if (fe_seen_q || (acc && beat.kind == cfo_pkg::K_FE))
               ek_q <= cfo_pkg::E_FE;
            else
               ek_q <= cfo_pkg::E_LINE;
         end
         if (emit_end)
         begin
            fs_phase_q <= (ek_q == cfo_pkg::E_FE);
            fe_seen_q  <= 1'b0;
         end
      end
   end

   // Line buffer: bytes appended back to back across ports
   always_ff @(posedge i_core_clk)
   begin
      if (acc && is_data && !fs_phase_q && wr_ptr_q != cfo_pkg::BUF_FULL)
         buf_mem[wr_ptr_q[cfo_pkg::BUF_AW-1:0]] <= beat.data;
   end

   // Fill pointer doubles as combined word count; CRC runs on the fly
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst || emit_end)
      begin
         wr_ptr_q <= 11'h000;
         crc_q    <= cfo_pkg::CRC_INIT;
      end
      else if (acc && is_data && !fs_phase_q && wr_ptr_q != cfo_pkg::BUF_FULL)
      begin
         wr_ptr_q <= wr_ptr_q + 11'h001;
         crc_q    <= crc_step(crc_q, beat.data);
      end
   end

   // Output byte selection: header, payload, footer
   always_comb
   begin
      logic [7:0]  di;
      logic [7:0]  wlo;
      logic [7:0]  whi;
      logic        last;
      di   = {vc_q, (ek_q == cfo_pkg::E_FS) ? cfo_pkg::DT_FS :
                    (ek_q == cfo_pkg::E_FE) ? cfo_pkg::DT_FE : dt_q};
      wlo  = (ek_q == cfo_pkg::E_LINE) ? wr_ptr_q[7:0] : 8'h00;
      whi  = (ek_q == cfo_pkg::E_LINE) ? {5'h00, wr_ptr_q[10:8]} : 8'h00;
      last = (ek_q == cfo_pkg::E_LINE) ? (ecnt_q == wr_ptr_q + cfo_pkg::FTR_LAST)
                                       : (ecnt_q == cfo_pkg::HDR_LEN - 11'h001);
      case (ecnt_q)
         11'h000: push_data = {last, di};
         11'h001: push_data = {last, wlo};
         11'h002: push_data = {last, whi};
         11'h003: push_data = {last, di ^ wlo ^ whi};
         default:
         begin
            if (ecnt_q < wr_ptr_q + cfo_pkg::HDR_LEN)
               push_data = {last, buf_mem[10'(ecnt_q - cfo_pkg::HDR_LEN)]};
            else if (!last)
               push_data = {last, crc_q[7:0]};
            else
               push_data = {last, crc_q[15:8]};
         end
      endcase
   end

   assign push_go  = (state_q == S_EMIT) && push_rdy;
   assign emit_end = push_go && push_data[8];

   // Emission counter, stalled by the output FIFO
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst || emit_end)
         ecnt_q <= 11'h000;
      else if (push_go)
         ecnt_q <= ecnt_q + 11'h001;
   end

   // Buffer between framer and the slow byte clock; its ready stalls emission
   cfo_fifo #(
      .W     (cfo_pkg::FIFO_W),
      .DEPTH (cfo_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk   (i_core_clk),
      .i_rst   (i_rst),
      .i_valid (state_q == S_EMIT),
      .o_ready (push_rdy),
      .i_data  (push_data),
      .o_valid (pop_valid),
      .i_ready (pop),
      .o_data  (pop_data)
   );

   // Drain one byte per rising byte clock edge, only while port zero drives data
   assign pop = link_edge && pop_valid && tx_ctl_q[cfo_pkg::TX_EN_BIT] && pins_ok[0];

   // Per transmit port pin state
   genvar k;
   generate
      for (k = 0; k < 2; k++)
      begin : g_tx
         assign active[k]  = |(i_rx_lock & ((k == 1) ? map1 : ~map1));
         assign pins_ok[k] = pdb_sync_q[1] && gen_q[cfo_pkg::GEN_SLEEP_BIT]
                             && gen_q[cfo_pkg::GEN_OEN_BIT] && active[k];
         always_ff @(posedge i_core_clk)
         begin
            if (i_rst || !pdb_sync_q[1])
               tx_q[k] <= '0;
            else if (!gen_q[cfo_pkg::GEN_SLEEP_BIT])
               tx_q[k] <= '{drive: 1'b1, hs_zero: 1'b1, valid: 1'b0, last: 1'b0,
                            data: 8'h00};
            else if (!pins_ok[k])
               tx_q[k] <= '0;
            else
               tx_q[k] <= '{drive: 1'b1, hs_zero: 1'b0,
                            valid: pop && ((k == 0) || repl),
                            last: pop_data[8], data: pop_data[7:0]};
         end
      end
   endgenerate

   // Checking helpers
   logic       in_frame_h;
   logic [3:0] done_h;
   logic [10:0] pay_h;
   logic [3:0]  lock_h;
   logic [3:0]  map_h;
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         in_frame_h <= 1'b0;
         done_h     <= 4'h0;
         pay_h      <= 11'h000;
         lock_h     <= 4'h0;
         map_h      <= 4'h0;
      end
      else
      begin
         // Lock and map as the pin logic saw them one cycle back
         lock_h <= i_rx_lock;
         map_h  <= fwd_one_q[3:0];
         if (push_go && ecnt_q == 11'h000 && ek_q != cfo_pkg::E_LINE)
            in_frame_h <= (ek_q == cfo_pkg::E_FS);
         if (emit_end)
            done_h <= 4'h0;
         else if (acc && beat.kind == cfo_pkg::K_LAST && !fs_phase_q)
            done_h[port_q] <= 1'b1;
         if (emit_end)
            pay_h <= 11'h000;
         else if (push_go && ecnt_q >= cfo_pkg::HDR_LEN && ecnt_q < wr_ptr_q + cfo_pkg::HDR_LEN)
            pay_h <= pay_h + 11'h001;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   a_pd_pins_hiz: assert property (!pdb_sync_q[1] |=> !o_tx_zero.drive && !o_tx_one.drive)
      else $error("pins driven while powered down");
   a_sleep_hs_zero: assert property ((pdb_sync_q[1] && !gen_q[cfo_pkg::GEN_SLEEP_BIT])
      |=> o_tx_zero.drive && o_tx_zero.hs_zero && !o_tx_zero.valid)
      else $error("lanes not held in HS-0");
   a_oen_off_hiz: assert property ((pdb_sync_q[1] && gen_q[cfo_pkg::GEN_SLEEP_BIT]
      && !gen_q[cfo_pkg::GEN_OEN_BIT]) |=> !o_tx_zero.drive && !o_tx_one.drive)
      else $error("pins driven with drive enable off");
   a_normal_valid: assert property ((pdb_sync_q[1] && gen_q[1:0] == 2'b11)
      |=> o_tx_zero.drive == |(lock_h & ~map_h) && !o_tx_zero.hs_zero)
      else $error("normal mode pin state wrong");
   a_lock_mapped: assert property ((pdb_sync_q[1] && gen_q[1:0] == 2'b11)
      |=> o_tx_one.drive == |(lock_h & map_h))
      else $error("port one activity does not follow mapped lock");
   a_replica_same: assert property ((repl && pins_ok[1])
      |=> o_tx_one.valid == o_tx_zero.valid
          && (!o_tx_zero.valid || {o_tx_one.last, o_tx_one.data} == {o_tx_zero.last, o_tx_zero.data}))
      else $error("replica differs from port zero");
   a_single_fs: assert property ((push_go && ecnt_q == 11'h000 && ek_q == cfo_pkg::E_FS)
      |-> !in_frame_h)
      else $error("second frame start in one frame");
   a_all_lines_in: assert property ((push_go && ecnt_q == 11'h000 && ek_q == cfo_pkg::E_LINE)
      |-> (done_h & en) == en)
      else $error("line emitted before all ports buffered");
   // Each count byte is checked on its own push, so FIFO stalls cannot skew it
   a_word_count: assert property ((push_go && ek_q == cfo_pkg::E_LINE
      && ecnt_q == 11'h001) |-> push_data[7:0] == wr_ptr_q[7:0])
      else $error("header count low byte differs from payload");
   a_word_count_hi: assert property ((push_go && ek_q == cfo_pkg::E_LINE
      && ecnt_q == 11'h002) |-> push_data[7:0] == {5'h00, wr_ptr_q[10:8]})
      else $error("header count high byte differs from payload");
   a_no_padding: assert property ((push_go && ek_q == cfo_pkg::E_LINE
      && ecnt_q == wr_ptr_q + cfo_pkg::HDR_LEN) |-> pay_h == wr_ptr_q)
      else $error("payload length differs from buffered bytes");
   a_header_vc: assert property ((push_go && ecnt_q == 11'h000) |-> push_data[7:6] == vc_q)
      else $error("header channel wrong");

   c_frame_start: cover property (push_go && ecnt_q == 11'h000 && ek_q == cfo_pkg::E_FS);
   c_long_line:   cover property (emit_end && ek_q == cfo_pkg::E_LINE);
   c_replicated:  cover property (o_tx_one.valid && o_tx_one.last);
   c_fifo_stall:  cover property (state_q == S_EMIT && !push_rdy);
endmodule
`default_nettype wire

//--- cfo_rx_model.sv
// Receiver model at the far side of both transmit ports.
// Assumes the core clock samples the pins; makes the byte clock within frames.
`timescale 1ns/1ps
`default_nettype none
module cfo_rx_model (
   input  wire logic                 i_clk,
   input  wire logic                 i_run,
   input  wire cfo_pkg::cfo_tx_pin_s i_zero,
   input  wire cfo_pkg::cfo_tx_pin_s i_one,
   output logic                      o_byte_clk,
   output logic                      o_stb,
   output logic [8:0]                o_b0,
   output logic [8:0]                o_b1,
   output logic                      o_one_stb
);
   // Byte clock stands still outside frames, so stalls are exercised
   initial o_byte_clk = 1'b0;
   always #100 o_byte_clk = i_run ? ~o_byte_clk : 1'b0;

   // Capture a byte only while the pins are really driven
   always_ff @(posedge i_clk)
   begin
      o_stb     <= i_zero.valid & i_zero.drive;
      o_one_stb <= i_one.valid & i_one.drive;
      o_b0      <= {i_zero.last, i_zero.data};
      o_b1      <= {i_one.last, i_one.data};
   end
endmodule
`default_nettype wire

//--- csi2_forward_output_control_test.sv
// Self-checking bench for the concatenating framer and pin control.
// Assumes cfo_top and cfo_rx_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module csi2_forward_output_control_test;
   logic clk = 1'b0, rst = 1'b1, power_down_bar_pin = 1'b1, run = 1'b0, wr = 1'b0;
   logic [3:0] lock = 4'h0, rx_valid = 4'h0, rx_ready;
   cfo_pkg::cfo_rx_beat_s [3:0] rx_beat = '0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lfsr = 8'h1C, dt = 8'h00;
   cfo_pkg::cfo_tx_pin_s tx0, tx1;
   logic bclk, stb, one_stb;
   logic [8:0] b0, b1, e;
   logic [8:0] exp_q [$];
   logic [15:0] crc;
   logic [7:0] pl [5];
   int errors = 0, samples_checked = 0;

   cfo_top dut_u (.i_core_clk(clk), .i_rst(rst), .i_power_down_bar_pin(power_down_bar_pin),
      .i_tx_byte_clk(bclk), .i_rx_lock(lock), .i_rx_valid(rx_valid),
      .i_rx_beat(rx_beat), .o_rx_ready(rx_ready), .i_reg_wr(wr), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_tx_zero(tx0), .o_tx_one(tx1));
   cfo_rx_model rx_u (.i_clk(clk), .i_run(run), .i_zero(tx0), .i_one(tx1),
      .o_byte_clk(bclk), .o_stb(stb), .o_b0(b0), .o_b1(b1), .o_one_stb(one_stb));

   always #12.5 clk = ~clk;

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction

   task automatic chk_val(input string n, input logic [7:0] x, input logic [7:0] g);
      samples_checked++;
      if (g !== x)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic chk_byte(input string n, input logic [8:0] x, input logic [8:0] g);
      samples_checked++;
      if (g !== x)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic finish_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      #1 chk_val("rdata", x, rdata);
   endtask

   // One beat on a receive port; held until ready is sampled high
   task automatic send(input int p, input cfo_pkg::cfo_kind_e k, input logic [1:0] vc,
                       input logic [7:0] d);
      int n;
      n = 0;
      rx_beat[p] <= '{kind: k, vc: vc, dt: dt[5:0], data: d};
      rx_valid[p] <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rx_ready[p] !== 1'b1 && n < 500);
      if (n >= 500)
         errors++;
      rx_valid[p] <= 1'b0;
      @(posedge clk);
   endtask

   // Expected header: VC of the lowest forwarded port, count, check byte
   task automatic hdr(input logic [5:0] t, input logic [10:0] c, input logic l);
      logic [7:0] h0, h1, h2;
      h0 = {2'h1, t};
      h1 = c[7:0];
      h2 = {5'h00, c[10:8]};
      exp_q.push_back({1'b0, h0});
      exp_q.push_back({1'b0, h1});
      exp_q.push_back({1'b0, h2});
      exp_q.push_back({l, h0 ^ h1 ^ h2});
   endtask

   task automatic pay(input logic [7:0] d);
      crc = crc ^ {8'h00, d};
      for (int i = 0; i < 8; i++)
         crc = crc[0] ? (crc >> 1) ^ cfo_pkg::CRC_POLY : crc >> 1;
      exp_q.push_back({1'b0, d});
   endtask

   // Oldest expected byte against each captured byte, port one must mirror it
   always @(posedge clk)
   begin
      if (stb === 1'b1)
      begin
         e = exp_q.size() ? exp_q.pop_front() : 9'h1FF;
         chk_byte("tx zero byte", e, b0);
         chk_byte("tx one byte", e, b1);
         chk_val("tx one valid", 8'h01, {7'h00, one_stb});
      end
   end

   // Pin table: pdb, general config, lock, expected {drive,hs} of port zero, one
   logic [7:0] t_pdb [5] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
   logic [7:0] t_gen [5] = '{8'h03, 8'h00, 8'h01, 8'h03, 8'h03};
   logic [7:0] t_lck [5] = '{8'h0F, 8'h00, 8'h0F, 8'h0C, 8'h01};
   logic [7:0] t_exp [5] = '{8'h00, 8'h33, 8'h00, 8'h20, 8'h02};
   logic [7:0] r_adr [6] = '{8'h02, 8'h20, 8'h21, 8'h33, 8'h55, 8'h34};
   logic [7:0] r_exp [6] = '{8'h03, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h04};

   initial
   begin
      #200000;
      errors++;
      finish_test();
   end

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 6; i++)
         reg_rd(r_adr[i], r_exp[i]);
      reg_wr(8'h33, 8'h01);
      reg_wr(8'h21, 8'h80);
      reg_wr(8'h20, 8'hCC);
      lock <= 4'hF;
      run  <= 1'b1;
      hdr(6'h00, 11'h000, 1'b1);
      send(0, cfo_pkg::K_FS, 2'h1, 8'h00);
      send(1, cfo_pkg::K_FS, 2'h2, 8'h00);
      crc = cfo_pkg::CRC_INIT;
      dt  = 8'h2B;
      hdr(6'h2B, 11'h005, 1'b0);
      // Payload kept apart: the checker pops the expected queue meanwhile
      for (int i = 0; i < 5; i++)
      begin
         pl[i] = rnd();
         pay(pl[i]);
      end
      exp_q.push_back({1'b0, crc[7:0]});
      exp_q.push_back({1'b1, crc[15:8]});
      for (int i = 0; i < 5; i++)
         send(i < 3 ? 0 : 1, (i == 2 || i == 4) ? cfo_pkg::K_LAST : cfo_pkg::K_DATA,
              i < 3 ? 2'h1 : 2'h2, pl[i]);
      hdr(6'h01, 11'h000, 1'b1);
      send(0, cfo_pkg::K_FE, 2'h1, 8'h00);
      send(1, cfo_pkg::K_FE, 2'h2, 8'h00);
      for (int n = 0; n < 4000 && exp_q.size() > 0; n++)
         @(posedge clk);
      chk_val("queue left", 8'h00, exp_q.size());
      run <= 1'b0;
      reg_wr(8'h20, 8'hFC);
      reg_wr(8'h33, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         power_down_bar_pin  <= t_pdb[i][0];
         lock <= t_lck[i][3:0];
         reg_wr(8'h02, t_gen[i]);
         repeat (6) @(posedge clk);
         #1 chk_val("pin state", t_exp[i],
                    {2'h0, tx1.drive, tx1.hs_zero, 2'h0, tx0.drive, tx0.hs_zero});
      end
      // Port map of zero sends every receiver to port zero
      reg_wr(8'h20, 8'h00);
      lock <= 4'hC;
      repeat (4) @(posedge clk);
      #1 chk_val("pin state", 8'h02,
                 {2'h0, tx1.drive, tx1.hs_zero, 2'h0, tx0.drive, tx0.hs_zero});
      finish_test();
   end
endmodule
`default_nettype wire
